// ===== core/cmhc_rx_end.sv
/*
  Receiving end: deserialises the link, parses and checks the MAC
  header, forwards extended header bytes and, except in ATM and reserved frames, body bytes in arrival order.
  Assumes the link strobes come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module cmhc_rx_end
  import cmhc_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   reset,
  cmhc_link_if.rx_end link,
  output logic [7:0]  rxData,
  output logic        rxValid,
  output logic        rxIsExt,
  output logic        rxHeaderValid,
  output logic        rxHeaderError,
  output logic [1:0]  rxFrameTypeBits,
  output logic [4:0]  rxFrameTypeParamBits,
  output logic        rxExtHeaderPresentFlag,
  output logic [7:0]  rxExtHeaderLength,
  output logic [15:0] rxLengthWord,
  output logic        rxIsRequest,
  output logic [15:0] rxServiceIdentifier,
  output logic [7:0]  rxSlotsRequested,
  output logic [7:0]  rxConcatFrameCount,
  output logic        rxTlvValid,
  output logic [7:0]  rxTlvType,
  output logic [7:0]  rxTlvLength
);
  typedef enum logic [3:0] {
    R_FC = 4'h0, R_PARM = 4'h1, R_LENH = 4'h3, R_LENL = 4'h2, R_EXT = 4'h6,
    R_CHKH = 4'h7, R_CHKL = 4'h5, R_BODY = 4'h4, R_SKIP = 4'hC, R_DROP = 4'hD
  } cmhc_rx_state_t;

  typedef struct packed {
    cmhc_rx_state_t st;
    logic [7:0]     sr;
    logic [2:0]     bitCnt;
    logic [15:0]    crc;
    logic [7:0]     frameControlByte;
    logic [7:0]     headerParamByte;
    logic [15:0]    lengthWord;
    logic [7:0]     extLeft;
    logic [7:0]     checkHigh;
    logic [15:0]    bodyLeft;
    logic [1:0]     tlvPhase;
    logic [7:0]     tlvLeft;
    logic [7:0]     tlvHold;
    logic [7:0]     data;
    logic           valid;
    logic           isExt;
    logic           hdrValid;
    logic           hdrError;
    logic           isRequest;
    logic [15:0]    serviceIdentifier;
    logic [7:0]     slots;
    logic [7:0]     concatCount;
    logic           tlvValid;
    logic [7:0]     tlvType;
    logic [7:0]     tlvLength;
    logic [7:0]     extLength;
  } cmhc_rx_t;

  cmhc_rx_t           r_reg;
  cmhc_rx_t           r_next;
  logic [7:0]         byteVal;
  logic               byteDone;
  logic [7:0]         extLen;
  logic signed [16:0] bodyLen;
  logic [1:0]         frameType;
  logic [4:0]         frameParam;

  // ==========================================================
  // Byte assembly and header parsing
  always_comb begin
    r_next          = r_reg;
    r_next.valid    = 1'b0;
    r_next.hdrValid = 1'b0;
    r_next.hdrError = 1'b0;
    r_next.tlvValid = 1'b0;
    byteVal    = {link.bitData, r_reg.sr[7:1]};
    byteDone   = link.frameActive && link.bitValid && (r_reg.bitCnt == 3'h7);
    frameType  = r_reg.frameControlByte[TYPE_MSB:TYPE_LSB];
    frameParam = r_reg.frameControlByte[PARAM_MSB:PARAM_LSB];
    extLen     = r_reg.frameControlByte[EXT_BIT] ? r_reg.headerParamByte : 8'h00;
    bodyLen    = $signed({1'b0, r_reg.lengthWord}) - $signed({9'h000, extLen});

    if (!link.frameActive) begin
      r_next.st     = R_FC;
      r_next.bitCnt = 3'h0;
      r_next.crc    = CHECK_INIT;
    end else if (link.bitValid) begin
      r_next.sr     = byteVal;
      r_next.bitCnt = r_reg.bitCnt + 3'h1;
      if (r_reg.st inside {R_FC, R_PARM, R_LENH, R_LENL, R_EXT}) begin
        r_next.crc = cmhcCheckStep(r_reg.crc, link.bitData);
      end
    end

    if (byteDone) begin
      unique case (r_reg.st)
        R_FC: begin
          r_next.frameControlByte = byteVal;
          r_next.st = (byteVal[TYPE_MSB:PARAM_LSB] == STUFF_BYTE[TYPE_MSB:PARAM_LSB]) ? R_DROP : R_PARM;
        end
        R_PARM: begin
          r_next.headerParamByte = byteVal;
          r_next.extLeft = r_reg.frameControlByte[EXT_BIT] ? byteVal : 8'h00;
          r_next.extLength = r_reg.frameControlByte[EXT_BIT] ? byteVal : 8'h00;
          if (r_reg.frameControlByte[EXT_BIT] && byteVal > EXT_LEN_MAX) begin
            r_next.hdrError = 1'b1;
            r_next.st       = R_DROP;
          end else begin
            r_next.st = R_LENH;
          end
        end
        R_LENH: begin
          r_next.lengthWord[15:8] = byteVal;
          r_next.st = R_LENL;
        end
        R_LENL: begin
          r_next.lengthWord[7:0] = byteVal;
          r_next.tlvPhase = 2'h0;
          r_next.st = (r_reg.extLeft != 8'h00) ? R_EXT : R_CHKH;
        end
        R_EXT: begin
          r_next.data    = byteVal;
          r_next.valid   = 1'b1;
          r_next.isExt   = 1'b1;
          r_next.extLeft = r_reg.extLeft - 8'h01;
          unique case (r_reg.tlvPhase)
            2'h0: begin
              r_next.tlvHold  = byteVal;
              r_next.tlvPhase = 2'h1;
            end
            2'h1: begin
              r_next.tlvLeft  = byteVal;
              r_next.tlvPhase = (byteVal == 8'h00) ? 2'h0 : 2'h2;
              if (r_reg.tlvHold != 8'h00 && r_reg.tlvHold <= TLV_KNOWN_MAX) begin
                r_next.tlvValid  = 1'b1;
                r_next.tlvType   = r_reg.tlvHold;
                r_next.tlvLength = byteVal;
              end
            end
            default: begin
              r_next.tlvLeft = r_reg.tlvLeft - 8'h01;
              if (r_reg.tlvLeft == 8'h01) begin
                r_next.tlvPhase = 2'h0;
              end
            end
          endcase
          if (r_reg.extLeft == 8'h01) begin
            r_next.st = R_CHKH;
          end
        end
        R_CHKH: begin
          r_next.checkHigh = byteVal;
          r_next.st = R_CHKL;
        end
        R_CHKL: begin
          r_next.isRequest   = (frameType == CMHC_MACSPEC) && (frameParam == PARAM_REQUEST);
          r_next.slots       = r_reg.headerParamByte;
          r_next.concatCount = r_reg.headerParamByte;
          r_next.serviceIdentifier = r_reg.lengthWord;
          r_next.bodyLeft    = bodyLen[15:0];
          if ({r_reg.checkHigh, byteVal} != r_reg.crc) begin
            r_next.hdrError = 1'b1;
            r_next.st       = R_DROP;
          end else if (r_next.isRequest) begin
            r_next.hdrValid = 1'b1;
            r_next.st       = R_DROP;
          end else if (bodyLen < 0) begin
            r_next.hdrError = 1'b1;
            r_next.st       = R_DROP;
          end else begin
            r_next.hdrValid = 1'b1;
            if (bodyLen == 0) begin
              r_next.st = R_DROP;
            end else if (frameType == CMHC_ATM || frameType == CMHC_RSVD) begin
              r_next.st = R_SKIP;
            end else begin
              r_next.st = R_BODY;
            end
          end
        end
        R_BODY: begin
          r_next.data     = byteVal;
          r_next.valid    = 1'b1;
          r_next.isExt    = 1'b0;
          r_next.bodyLeft = r_reg.bodyLeft - 16'h0001;
          if (r_reg.bodyLeft == 16'h0001) begin
            r_next.st = R_DROP;
          end
        end
        R_SKIP: begin
          r_next.bodyLeft = r_reg.bodyLeft - 16'h0001;
          if (r_reg.bodyLeft == 16'h0001) begin
            r_next.st = R_DROP;
          end
        end
        R_DROP: r_next.st = R_DROP;
        default: r_next.st = R_DROP;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      r_reg     <= '0;
      r_reg.crc <= CHECK_INIT;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================
  // Outputs
  assign rxData                 = r_reg.data;
  assign rxValid                = r_reg.valid;
  assign rxIsExt                = r_reg.isExt;
  assign rxHeaderValid          = r_reg.hdrValid;
  assign rxHeaderError          = r_reg.hdrError;
  assign rxFrameTypeBits        = r_reg.frameControlByte[TYPE_MSB:TYPE_LSB];
  assign rxFrameTypeParamBits   = r_reg.frameControlByte[PARAM_MSB:PARAM_LSB];
  assign rxExtHeaderPresentFlag = r_reg.frameControlByte[EXT_BIT];
  assign rxExtHeaderLength      = r_reg.extLength;
  assign rxLengthWord           = r_reg.lengthWord;
  assign rxIsRequest            = r_reg.isRequest;
  assign rxServiceIdentifier    = r_reg.serviceIdentifier;
  assign rxSlotsRequested       = r_reg.slots;
  assign rxConcatFrameCount     = r_reg.concatCount;
  assign rxTlvValid             = r_reg.tlvValid;
  assign rxTlvType              = r_reg.tlvType;
  assign rxTlvLength            = r_reg.tlvLength;
endmodule
`default_nettype wire

// ===== core/cmhc_pkg.sv
/*
  Shared constants, types and the header check step for the cable MAC
  header codec. Assumes a single 200 MHz clock shared by both ends.
*/
package cmhc_pkg;
  // ==========================================================
  // Frame control byte layout
  localparam int TYPE_MSB  = 7;
  localparam int TYPE_LSB  = 6;
  localparam int PARAM_MSB = 5;
  localparam int PARAM_LSB = 1;
  localparam int EXT_BIT   = 0;

  typedef enum logic [1:0] {
    CMHC_PACKET  = 2'h0,
    CMHC_ATM     = 2'h1,
    CMHC_RSVD    = 2'h2,
    CMHC_MACSPEC = 2'h3
  } cmhc_frame_type_t;

  localparam logic [4:0]  PARAM_REQUEST = 5'h02;
  localparam logic [4:0]  PARAM_CONCAT  = 5'h1C;
  localparam logic [7:0]  STUFF_BYTE    = 8'hFF;
  localparam logic [7:0]  EXT_LEN_MAX   = 8'hF0;
  localparam logic [7:0]  TLV_KNOWN_MAX = 8'h0A;

  // ==========================================================
  // Check sequence
  localparam logic [15:0] CHECK_POLY = 16'h1021;
  localparam logic [15:0] CHECK_INIT = 16'hFFFF;

  // ==========================================================
  // Bit timing and buffering
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned BIT_PERIOD_NS  = 20;
  localparam int unsigned BIT_DIV_CYCLES = (BIT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0]  BIT_DIV_LAST   = 3'(BIT_DIV_CYCLES - 1);
  localparam int          FIFO_WIDTH     = 8;
  localparam int          FIFO_DEPTH     = 16;

  // One serial step of the generator x^16 + x^12 + x^5 + 1
  function automatic logic [15:0] cmhcCheckStep(input logic [15:0] crc, input logic b);
    logic fb;
    fb = crc[15] ^ b;
    return {crc[14:0], 1'b0} ^ (fb ? CHECK_POLY : 16'h0000);
  endfunction
endpackage

// ===== core/cmhc_link_if.sv
/*
  Serial link between the transmitting end and the receiving end.
  Assumes both ends share one clock; bitValid is a one-cycle strobe.
*/
`timescale 1ns/100ps
`default_nettype none
interface cmhc_link_if;
  logic frameActive;
  logic bitValid;
  logic bitData;

  modport tx_end (output frameActive, output bitValid, output bitData);
  modport rx_end (input frameActive, input bitValid, input bitData);
endinterface
`default_nettype wire

// ===== core/cmhc_byte_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes the single system clock and asynchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module cmhc_byte_fifo
  import cmhc_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wrPtr;
    logic [AW-1:0]               rdPtr;
    logic [CW-1:0]               count;
    logic                        ready;
  } cmhc_fifo_state_t;

  cmhc_fifo_state_t state_reg;
  cmhc_fifo_state_t state_next;
  logic             doPush;
  logic             doPop;

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;
    doPush     = inValid && state_reg.ready;
    doPop      = outReady && (state_reg.count != '0);
    if (doPush) begin
      state_next.mem[state_reg.wrPtr] = inData;
      state_next.wrPtr = (state_reg.wrPtr == AW'(DEPTH - 1)) ? '0 : state_reg.wrPtr + AW'(1);
    end
    if (doPop) begin
      state_next.rdPtr = (state_reg.rdPtr == AW'(DEPTH - 1)) ? '0 : state_reg.rdPtr + AW'(1);
    end
    state_next.count = state_reg.count + CW'(doPush) - CW'(doPop);
    state_next.ready = (state_next.count != CW'(DEPTH));
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_reg       <= '0;
      state_reg.ready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign inReady  = state_reg.ready;
  assign outData  = state_reg.mem[state_reg.rdPtr];
  assign outValid = (state_reg.count != '0);
endmodule
`default_nettype wire

// ===== core/cmhc_tx_end.sv
/*
  Transmitting end: builds the MAC header, appends the check sequence
  and serialises header, extended header and body bytes from a FIFO.
  Assumes the user pushes exactly the extended header bytes, then the
  body bytes, for each accepted frame.
*/
`timescale 1ns/100ps
`default_nettype none
module cmhc_tx_end
  import cmhc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       txStart,
  input  wire logic [7:0] txFrameControlByte,
  input  wire logic [7:0] txHeaderParamByte,
  input  wire logic [15:0] txLengthWord,
  input  wire logic [7:0] txData,
  input  wire logic       txValid,
  output logic            txReady,
  output logic            txBusy,
  output logic            txRefused,
  cmhc_link_if.tx_end     link
);
  typedef enum logic [3:0] {
    T_IDLE = 4'h0, T_FC = 4'h1, T_PARM = 4'h3, T_LENH = 4'h2, T_LENL = 4'h6,
    T_EXT = 4'h7, T_CHKH = 4'h5, T_CHKL = 4'h4, T_BODY = 4'hC
  } cmhc_tx_state_t;

  typedef struct packed {
    cmhc_tx_state_t st;
    logic [2:0]     div;
    logic [7:0]     sr;
    logic [2:0]     bitCnt;
    logic           loaded;
    logic [15:0]    crc;
    logic [7:0]     frameControlByte;
    logic [7:0]     headerParamByte;
    logic [15:0]    lengthWord;
    logic [7:0]     extLeft;
    logic [15:0]    bodyLeft;
    logic           frameActive;
    logic           bitValid;
    logic           bitData;
    logic           busy;
    logic           refused;
  } cmhc_tx_t;

  cmhc_tx_t         r_reg;
  cmhc_tx_t         r_next;
  logic [7:0]       fifoData;
  logic             fifoValid;
  logic             fifoPop;
  logic [7:0]       extLen;
  logic signed [16:0] bodyLen;
  logic             isRequest;
  logic             tick;
  logic             inHeader;

  cmhc_byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .inData   (txData),
    .inValid  (txValid),
    .inReady  (txReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // ==========================================================
  // Frame sequencing
  always_comb begin
    r_next    = r_reg;
    r_next.bitValid = 1'b0;
    r_next.refused  = 1'b0;
    extLen    = txFrameControlByte[EXT_BIT] ? txHeaderParamByte : 8'h00;
    isRequest = (txFrameControlByte[TYPE_MSB:TYPE_LSB] == CMHC_MACSPEC)
             && (txFrameControlByte[PARAM_MSB:PARAM_LSB] == PARAM_REQUEST);
    bodyLen   = $signed({1'b0, txLengthWord}) - $signed({9'h000, extLen});
    tick      = (r_reg.div == BIT_DIV_LAST);
    inHeader  = (r_reg.st inside {T_FC, T_PARM, T_LENH, T_LENL, T_EXT});
    fifoPop   = r_reg.busy && !r_reg.loaded && (r_reg.st inside {T_EXT, T_BODY});

    if (r_reg.st == T_IDLE) begin
      r_next.busy        = 1'b0;
      r_next.frameActive = 1'b0;
      if (txStart && !r_reg.busy) begin
        if (txFrameControlByte[TYPE_MSB:PARAM_LSB] == STUFF_BYTE[TYPE_MSB:PARAM_LSB]) begin
          r_next.refused = 1'b1;
        end else if (extLen > EXT_LEN_MAX) begin
          r_next.refused = 1'b1;
        end else if (!isRequest && bodyLen < 0) begin
          r_next.refused = 1'b1;
        end else begin
          r_next.st               = T_FC;
          r_next.frameControlByte = txFrameControlByte;
          r_next.headerParamByte  = txHeaderParamByte;
          r_next.lengthWord       = txLengthWord;
          r_next.extLeft          = extLen;
          r_next.bodyLeft         = isRequest ? 16'h0000 : bodyLen[15:0];
          r_next.crc              = CHECK_INIT;
          r_next.div              = 3'h0;
          r_next.bitCnt           = 3'h0;
          r_next.loaded           = 1'b0;
          r_next.busy             = 1'b1;
          r_next.frameActive      = 1'b1;
        end
      end
    end else begin
      r_next.div = tick ? 3'h0 : r_reg.div + 3'h1;
      if (!r_reg.loaded) begin
        r_next.loaded = 1'b1;
        unique case (r_reg.st)
          T_FC:   r_next.sr = r_reg.frameControlByte;
          T_PARM: r_next.sr = r_reg.headerParamByte;
          T_LENH: r_next.sr = r_reg.lengthWord[15:8];
          T_LENL: r_next.sr = r_reg.lengthWord[7:0];
          T_CHKH: r_next.sr = r_reg.crc[15:8];
          T_CHKL: r_next.sr = r_reg.crc[7:0];
          default: begin
            r_next.sr     = fifoData;
            r_next.loaded = fifoValid;
          end
        endcase
      end else if (tick) begin
        r_next.bitValid = 1'b1;
        r_next.bitData  = r_reg.sr[0];
        r_next.sr       = {1'b0, r_reg.sr[7:1]};
        r_next.bitCnt   = r_reg.bitCnt + 3'h1;
        if (inHeader) begin
          r_next.crc = cmhcCheckStep(r_reg.crc, r_reg.sr[0]);
        end
        if (r_reg.bitCnt == 3'h7) begin
          r_next.loaded = 1'b0;
          unique case (r_reg.st)
            T_FC:   r_next.st = T_PARM;
            T_PARM: r_next.st = T_LENH;
            T_LENH: r_next.st = T_LENL;
            T_LENL: r_next.st = (r_reg.extLeft != 8'h00) ? T_EXT : T_CHKH;
            T_EXT: begin
              r_next.extLeft = r_reg.extLeft - 8'h01;
              if (r_reg.extLeft == 8'h01) begin
                r_next.st = T_CHKH;
              end
            end
            T_CHKH: r_next.st = T_CHKL;
            T_CHKL: r_next.st = (r_reg.bodyLeft != 16'h0000) ? T_BODY : T_IDLE;
            T_BODY: begin
              r_next.bodyLeft = r_reg.bodyLeft - 16'h0001;
              if (r_reg.bodyLeft == 16'h0001) begin
                r_next.st = T_IDLE;
              end
            end
            default: r_next.st = T_IDLE;
          endcase
        end
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign txBusy           = r_reg.busy;
  assign txRefused        = r_reg.refused;
  assign link.frameActive = r_reg.frameActive;
  assign link.bitValid    = r_reg.bitValid;
  assign link.bitData     = r_reg.bitData;
endmodule
`default_nettype wire

// ===== tb/cmhc_link_checker.sv
/*
  Link checker for the MAC header codec.
  Assumes one clock for both ends; connected to the link interface.
*/
`timescale 1ns/100ps
`default_nettype none
module cmhc_link_checker
  import cmhc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic frameActive,
  input wire logic bitValid,
  input wire logic bitData
);
  // ==========================================================
  // Bit count and first four bytes of the frame
  logic [19:0] bitCnt;
  logic [31:0] sh;
  logic        isReq;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bitCnt <= 20'h0_0000;
      sh     <= 32'h0000_0000;
    end else if (!frameActive) begin
      bitCnt <= 20'h0_0000;
    end else if (bitValid) begin
      bitCnt <= bitCnt + 20'h0_0001;
      if (bitCnt < 20'h0_0020) begin
        sh <= {bitData, sh[31:1]};
      end
    end
  end
  assign isReq = (sh[7:1] == {2'h3, PARAM_REQUEST});
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // ==========================================================
  // Assertions
  valid_in_frame_a: assert property (bitValid |-> frameActive)
    else $error("bit strobe outside frame");
  bit_spacing_a: assert property (bitValid |=> !bitValid [*3])
    else $error("bits closer than four cycles");
  whole_bytes_a: assert property ($fell(frameActive) |-> bitCnt[2:0] == 3'h0)
    else $error("frame ends inside a byte");
  frame_end_a: assert property ($fell(frameActive) |-> $past(bitValid))
    else $error("frame not closed after last bit");
  no_stuff_a: assert property (frameActive && bitCnt == 20'h0_0008 |-> sh[31:25] != STUFF_BYTE[7:1])
    else $error("stuff byte sent as control byte");
  ext_len_a: assert property (frameActive && bitCnt == 20'h0_0010 && sh[16] |-> sh[31:24] <= EXT_LEN_MAX)
    else $error("extension longer than limit");
  len_cover_a: assert property (frameActive && bitCnt == 20'h0_0020 && sh[0] && !isReq
    |-> {sh[23:16], sh[31:24]} >= {8'h00, sh[15:8]})
    else $error("length word below extension length");
  frame_len_a: assert property ($fell(frameActive) |-> bitCnt == (isReq ? 20'h0_0030 :
    {1'b0, {sh[23:16], sh[31:24]} + 16'h0006, 3'h0}))
    else $error("frame size differs from length word");
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
/*
  Testbench joining both codec ends over the link interface.
  Assumes the designs and package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import cmhc_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b1;
  logic        txStart = 1'b0;
  logic        txValid = 1'b0;
  logic [7:0]  txFrameControlByte = 8'h00;
  logic [7:0]  txHeaderParamByte = 8'h00;
  logic [7:0]  txData = 8'h00;
  logic [15:0] txLengthWord = 16'h0000;
  logic        txReady, txBusy, txRefused, rxValid, rxIsExt, rxHeaderValid, rxHeaderError;
  logic        rxExtHeaderPresentFlag, rxIsRequest, rxTlvValid;
  logic [1:0]  rxFrameTypeBits;
  logic [4:0]  rxFrameTypeParamBits;
  logic [7:0]  rxData, rxExtHeaderLength, rxSlotsRequested, rxConcatFrameCount, rxTlvType, rxTlvLength;
  logic [15:0] rxLengthWord, rxServiceIdentifier;
  logic [15:0] tlvLast;
  logic [7:0]  lf = 8'h56;
  logic [8:0]  got[$];
  logic [8:0]  exp[$];
  int          error_cnt = 0, total_checks = 0, hv = 0, he = 0, refc = 0, tlvc = 0;
  always #2.5 ref_clk = ~ref_clk;
  // ==========================================================
  // Design ends and checker
  cmhc_link_if cmhc_link_if_inst ();
  cmhc_tx_end cmhc_tx_end_inst (.ref_clk, .reset, .txStart, .txFrameControlByte, .txHeaderParamByte,
    .txLengthWord, .txData, .txValid, .txReady, .txBusy, .txRefused, .link(cmhc_link_if_inst));
  cmhc_rx_end cmhc_rx_end_inst (.ref_clk, .reset, .link(cmhc_link_if_inst), .rxData, .rxValid, .rxIsExt,
    .rxHeaderValid, .rxHeaderError, .rxFrameTypeBits, .rxFrameTypeParamBits, .rxExtHeaderPresentFlag,
    .rxExtHeaderLength, .rxLengthWord, .rxIsRequest, .rxServiceIdentifier, .rxSlotsRequested,
    .rxConcatFrameCount, .rxTlvValid, .rxTlvType, .rxTlvLength);
  cmhc_link_checker cmhc_link_checker_inst (.ref_clk, .reset, .frameActive(cmhc_link_if_inst.frameActive),
    .bitValid(cmhc_link_if_inst.bitValid), .bitData(cmhc_link_if_inst.bitData));
  // ==========================================================
  // Monitor, helpers
  always @(negedge ref_clk) begin
    if (rxValid === 1'b1) got.push_back({rxIsExt, rxData});
    if (rxHeaderValid === 1'b1) hv++;
    if (rxHeaderError === 1'b1) he++;
    if (txRefused === 1'b1) refc++;
    if (rxTlvValid === 1'b1) begin
      tlvc++;
      tlvLast = {rxTlvType, rxTlvLength};
    end
  end
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("Error %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic push(input logic [7:0] q[$], output int n);
    n = 0;
    for (int t = 0; t < 9000 && n < q.size(); t++) begin
      @(negedge ref_clk);
      txValid = (txReady === 1'b1);
      if (txValid) begin
        txData = q[n];
        n++;
      end
    end
    @(negedge ref_clk);
    txValid = 1'b0;
    if (n < q.size()) begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic frame(input logic [7:0] fc, pb, input logic [15:0] len, input logic [7:0] q[$],
                       input int nExt, input bit refuse);
    int h0, r0, k;
    h0 = hv;
    r0 = refc;
    exp.delete();
    got.delete();
    foreach (q[i]) if (i < nExt || fc[7] == fc[6]) exp.push_back({i < nExt, q[i]});
    @(negedge ref_clk);
    {txFrameControlByte, txHeaderParamByte, txLengthWord, txStart} = {fc, pb, len, 1'b1};
    @(negedge ref_clk);
    txStart = 1'b0;
    chk("txBusy", txBusy, !refuse);
    for (k = 0; k < 9000 && txBusy === 1'b1; k++) @(negedge ref_clk);
    if (k == 9000) begin
      error_cnt++;
      final_report();
    end
    repeat (4) @(negedge ref_clk);
    chk("txRefused", refc - r0, refuse);
    if (refuse) return;
    chk("headers", hv - h0, 1);
    chk("bytes", got.size(), exp.size());
    foreach (exp[i]) chk("byte", got[i], exp[i]);
    chk("type", rxFrameTypeBits, fc[7:6]);
    chk("param", rxFrameTypeParamBits, fc[5:1]);
    chk("ext", {rxExtHeaderPresentFlag, rxExtHeaderLength}, {fc[0], fc[0] ? pb : 8'h00});
    if (fc[7:1] == {2'h3, PARAM_REQUEST}) chk("request", {rxIsRequest, rxServiceIdentifier, rxSlotsRequested},
      {1'b1, len, pb});
    else chk("length", rxLengthWord, len);
    if (fc[7:1] == {2'h3, PARAM_CONCAT}) chk("count", rxConcatFrameCount, pb);
    chk("errors", he, 0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    int n;
    logic [7:0] q[$];
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    q = {8'h01, 8'h02, rnd(), rnd()};
    repeat (6) q.push_back(rnd());
    push(q, n);
    frame(8'h01, 8'h04, 16'h000A, q, 4, 0);
    chk("tuple", {tlvc[7:0], tlvLast}, {8'h01, 8'h01, 8'h02});
    q = {8'h20, 8'h01, rnd(), rnd()};
    push(q, n);
    frame(8'h01, 8'h04, 16'h0004, q, 4, 0);
    chk("unknown", tlvc, 1);
    for (int ft = 0; ft < 3; ft++) begin
      q.delete();
      repeat (5) q.push_back(rnd());
      push(q, n);
      frame({ft[1:0], 6'h00}, 8'h00, 16'h0005, q, 0, 0);
    end
    q.delete();
    frame({2'h3, PARAM_REQUEST, 1'b0}, rnd(), {rnd(), rnd()}, q, 0, 0);
    repeat (16) q.push_back(rnd());
    push(q, n);
    chk("fill", n, FIFO_DEPTH);
    chk("ready", txReady, 0);
    frame({2'h3, PARAM_CONCAT, 1'b0}, 8'h02, 16'h0010, q, 0, 0);
    frame(STUFF_BYTE, 8'h00, 16'h0000, q, 0, 1);
    frame(8'hFE, 8'h00, 16'h0000, q, 0, 1);
    frame(8'h01, 8'hF1, 16'h00F1, q, 0, 1);
    q.delete();
    for (int i = 0; i < 240; i++) q.push_back(i % 16 == 0 ? 8'h30 : i % 16 == 1 ? 8'h0E : rnd());
    fork
      push(q, n);
      frame(8'h01, 8'hF0, 16'h00F0, q, 240, 0);
    join
    chk("unknown", tlvc, 1);
    final_report();
  end
endmodule
`default_nettype wire
